// [core/hwpd_pkg.sv]
// constants, field layouts and carrier types for the head write pulse decoder
// assumes a 40 MHz system clock and a serial write clock near 3 MHz
package hwpd_pkg;

    // --------
    // timing
    // --------
    localparam int CLK_NS      = 25;
    localparam int BIT_NS      = 325;
    localparam int IDLE_NS     = 2 * BIT_NS;
    localparam int IDLE_CYCLES = (IDLE_NS + CLK_NS - 1) / CLK_NS;

    // --------
    // serial word layout
    // --------
    localparam int WORD_BITS = 32;
    localparam int MODE_BITS = 3;
    localparam int NUM_CH    = 8;
    localparam int DPS_POS   = 0;
    localparam int APS_POS   = 1;
    localparam int ERA_POS   = 2;
    localparam int DIR_POS   = MODE_BITS;
    localparam int CMD_BITS  = MODE_BITS + NUM_CH;

    // --------
    // outputs and channel sequence
    // --------
    localparam int NUM_OUT     = 10;
    localparam int OUT_AUX_A   = 0;
    localparam int OUT_AUX_B   = 1;
    localparam int OUT_CH_BASE = 2;
    localparam logic [3:0] SLOT_AUX   = 4'h0;
    localparam logic [3:0] SLOT_CLAMP = 4'h9;
    localparam logic [1:0] SLOT_EDGES = 2'h3;

    // --------
    // register map
    // --------
    localparam logic [7:0]  REG_CONTROL = 8'h00;
    localparam logic [7:0]  REG_STATUS  = 8'h04;
    localparam logic [7:0]  REG_WORD    = 8'h08;
    localparam logic [7:0]  REG_COUNT   = 8'h0C;
    localparam logic [31:0] CONTROL_RST = 32'h0000_0000;
    localparam logic [31:0] WORD_RST    = 32'h0000_0003;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [NUM_CH-1:0] channel_direction_bits;
        logic              aux_erase_select;
        logic              aux_playback_select;
        logic              data_playback_select;
    } cmd_t;

endpackage

// [core/sync2.sv]
// two flip-flop synchroniser for a group of pin inputs
// assumes the inputs are asynchronous to sys_clk
`timescale 1ns/100ps
`default_nettype none
module sync2 #(
    parameter int W = 1
) (
    input  wire logic         sys_clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            meta <= '0;
            q    <= '0;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule
`default_nettype wire

// [core/serial_word_rx.sv]
// shifts in the 32-bit serial word on rising write clock edges
// assumes synchronised write clock and data; a long idle gap restarts framing
`timescale 1ns/100ps
`default_nettype none
module serial_word_rx
    import hwpd_pkg::*;
(
    input  wire logic                 sys_clk,
    input  wire logic                 rst,
    input  wire logic                 wclk_s,
    input  wire logic                 wdata_s,
    output logic                      bit_tick,
    output logic                      word_valid,
    output logic      [WORD_BITS-1:0] word
);
    logic                 wclk_d;
    logic [4:0]           bit_cnt;
    logic [7:0]           idle_cnt;
    logic [WORD_BITS-1:0] shift;
    logic                 rise;

    assign rise = wclk_s & ~wclk_d;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wclk_d   <= 1'b0;
            bit_tick <= 1'b0;
        end else begin
            wclk_d   <= wclk_s;
            bit_tick <= rise;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            idle_cnt <= 8'h00;
        end else if (rise) begin
            idle_cnt <= 8'h00;
        end else if (idle_cnt != 8'(IDLE_CYCLES)) begin
            idle_cnt <= idle_cnt + 8'h01;
        end
    end

    // mode bits arrive first, sampled on the rising edge
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            bit_cnt    <= 5'h00;
            shift      <= '0;
            word       <= WORD_RST;
            word_valid <= 1'b0;
        end else begin
            word_valid <= 1'b0;
            if (rise) begin
                shift[bit_cnt] <= wdata_s;
                bit_cnt        <= bit_cnt + 5'h01;
                if (bit_cnt == 5'(WORD_BITS - 1)) begin
                    word          <= shift;
                    word[bit_cnt] <= wdata_s;
                    word_valid    <= 1'b1;
                end
            end else if (idle_cnt == 8'(IDLE_CYCLES)) begin
                bit_cnt <= 5'h00;
            end
        end
    end
endmodule
`default_nettype wire

// [core/head_write_pulse_decoder.sv]
// head write pulse decoder: serial command intake, channel sequencing,
// standby control and switch drive, with an AXI4-Lite register slave
// assumes write clock, write data, standby and short inputs are asynchronous
// Summary of operation
// - 32-bit serial word shifted with write clock
// - first three bits set operating mode
// - direction bit high forward, low reverse
// - standby pin high forces standby
// - both playback selects high means standby
// - after pin falls, standby until select cleared
// - standby: amplifier, switches, reference, erase off
// - channels selected in fixed sequence, one driven
// - unselected outputs left floating
// - high closes upper switch, low lower
// - aux write adds extra aux current
// - aux erase bit adds erase current
// - clamp takes current when nothing selected
// - detected output short forces standby three clocks later
// - short clears, operation resumes, word kept
// - select zero writes channel; erase otherwise ignored
`timescale 1ns/100ps
`default_nettype none
module head_write_pulse_decoder
    import hwpd_pkg::*;
(
    input  wire logic               sys_clk,
    input  wire logic               rst,
    input  wire logic               wclk,
    input  wire logic               wdata,
    input  wire logic               standby_in,
    input  wire logic               short_detect,
    input  wire logic [7:0]         s_axi_awaddr,
    input  wire logic               s_axi_awvalid,
    output logic                    s_axi_awready,
    input  wire logic [31:0]        s_axi_wdata,
    input  wire logic [3:0]         s_axi_wstrb,
    input  wire logic               s_axi_wvalid,
    output logic                    s_axi_wready,
    output logic [1:0]              s_axi_bresp,
    output logic                    s_axi_bvalid,
    input  wire logic               s_axi_bready,
    input  wire logic [7:0]         s_axi_araddr,
    input  wire logic               s_axi_arvalid,
    output logic                    s_axi_arready,
    output logic [31:0]             s_axi_rdata,
    output logic [1:0]              s_axi_rresp,
    output logic                    s_axi_rvalid,
    input  wire logic               s_axi_rready,
    output logic [NUM_OUT-1:0]      hi_switch,
    output logic [NUM_OUT-1:0]      lo_switch,
    output logic                    amp_enable,
    output logic                    vref_enable,
    output logic                    erase_enable,
    output logic                    aux_current_enable,
    output logic                    clamp_enable
);

    // ----------------------------------------
    // declarations
    // ----------------------------------------
    logic [3:0]           pins_s;
    logic                 wclk_s;
    logic                 wdata_s;
    logic                 standby_s;
    logic                 short_s;
    logic                 bit_tick;
    logic                 word_valid;
    logic [WORD_BITS-1:0] rx_word;
    logic [WORD_BITS-1:0] held_word;
    cmd_t                 cmd;
    cmd_t                 rx_cmd;
    logic                 standby_latch;
    logic                 standby_now;
    logic [3:0]           slot;
    logic [1:0]           edge_cnt;
    logic [15:0]          word_count;
    logic [31:0]          control;
    logic [7:0]           aw_addr;
    logic [31:0]          w_data;
    logic [3:0]           w_strb;
    logic [31:0]          read_value;
    logic                 read_hit;
    logic                 elem_write;
    logic                 elem_dir;
    logic [NUM_OUT-1:0]   next_hi;
    logic [NUM_OUT-1:0]   next_lo;
    logic                 next_clamp;

    // ----------------------------------------
    // decode helpers
    // ----------------------------------------
    // positive pin of the element in a slot; negative pin is the aux b line
    function automatic logic [NUM_OUT-1:0] pos_pin(input logic [3:0] s);
        logic [NUM_OUT-1:0] v;
        v = '0;
        if (s == SLOT_AUX) begin
            v[OUT_AUX_A] = 1'b1;
        end else if (s < SLOT_CLAMP) begin
            v[OUT_CH_BASE + int'(s) - 1] = 1'b1;
        end
        return v;
    endfunction

    function automatic logic [31:0] apply_strb(input logic [31:0] old,
                                               input logic [31:0] nw,
                                               input logic [3:0]  strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction

    // ----------------------------------------
    // pin synchronisers and serial intake
    // ----------------------------------------
    sync2 #(
        .W (4)
    ) u_sync (
        .sys_clk (sys_clk),
        .rst     (rst),
        .d       ({short_detect, standby_in, wdata, wclk}),
        .q       (pins_s)
    );

    assign wclk_s    = pins_s[0];
    assign wdata_s   = pins_s[1];
    assign standby_s = pins_s[2];
    assign short_s   = pins_s[3];

    serial_word_rx u_rx (
        .sys_clk    (sys_clk),
        .rst        (rst),
        .wclk_s     (wclk_s),
        .wdata_s    (wdata_s),
        .bit_tick   (bit_tick),
        .word_valid (word_valid),
        .word       (rx_word)
    );

    assign rx_cmd = cmd_t'(rx_word[CMD_BITS-1:0]);
    assign cmd    = cmd_t'(held_word[CMD_BITS-1:0]);

    // ----------------------------------------
    // held word and counters
    // ----------------------------------------
    // a short never touches the held word
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            held_word <= WORD_RST;
        end else if (word_valid) begin
            held_word <= rx_word;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            word_count <= 16'h0000;
        end else if (word_valid) begin
            word_count <= word_count + 16'h0001;
        end
    end

    // ----------------------------------------
    // standby control
    // ----------------------------------------
    // set while the pin is high; a new word with a select low releases it
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            standby_latch <= 1'b0;
        end else if (standby_s) begin
            standby_latch <= 1'b1;
        end else if (word_valid && (!rx_cmd.data_playback_select ||
                                    !rx_cmd.aux_playback_select)) begin
            standby_latch <= 1'b0;
        end
    end

    assign standby_now = standby_s | standby_latch | short_s | control[0]
                       | (cmd.data_playback_select & cmd.aux_playback_select);

    // ----------------------------------------
    // channel sequencer
    // ----------------------------------------
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            slot     <= SLOT_AUX;
            edge_cnt <= 2'h0;
        end else if (word_valid) begin
            slot     <= SLOT_AUX;
            edge_cnt <= 2'h0;
        end else if (bit_tick) begin
            if (edge_cnt == SLOT_EDGES - 2'h1) begin
                edge_cnt <= 2'h0;
                slot     <= (slot == SLOT_CLAMP) ? SLOT_AUX : slot + 4'h1;
            end else begin
                edge_cnt <= edge_cnt + 2'h1;
            end
        end
    end

    // ----------------------------------------
    // switch and current decode
    // ----------------------------------------
    always_comb begin
        elem_write = 1'b0;
        elem_dir   = 1'b0;
        if (slot == SLOT_AUX) begin
            elem_write = !cmd.aux_playback_select;
            elem_dir   = cmd.aux_erase_select;
        end else if (slot < SLOT_CLAMP) begin
            elem_write = !cmd.data_playback_select;
            elem_dir   = cmd.channel_direction_bits[slot[2:0] - 3'h1];
        end
    end

    always_comb begin
        next_hi    = '0;
        next_lo    = '0;
        next_clamp = 1'b0;
        if (!standby_now) begin
            if (elem_write) begin
                if (elem_dir) begin
                    next_hi                = pos_pin(slot);
                    next_lo[OUT_AUX_B]     = 1'b1;
                end else begin
                    next_lo                = pos_pin(slot);
                    next_hi[OUT_AUX_B]     = 1'b1;
                end
            end else begin
                next_clamp = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            hi_switch          <= '0;
            lo_switch          <= '0;
            amp_enable         <= 1'b0;
            vref_enable        <= 1'b0;
            erase_enable       <= 1'b0;
            aux_current_enable <= 1'b0;
            clamp_enable       <= 1'b0;
        end else begin
            hi_switch          <= next_hi;
            lo_switch          <= next_lo;
            amp_enable         <= !standby_now;
            vref_enable        <= !standby_now;
            clamp_enable       <= next_clamp;
            aux_current_enable <= !standby_now && elem_write && slot == SLOT_AUX;
            erase_enable       <= !standby_now && elem_write && slot == SLOT_AUX
                                  && cmd.aux_erase_select;
        end
    end

    // ----------------------------------------
    // AXI4-Lite write channel
    // ----------------------------------------
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
            aw_addr       <= 8'h00;
            w_data        <= 32'h0000_0000;
            w_strb        <= 4'h0;
            control       <= CONTROL_RST;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr       <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data       <= s_axi_wdata;
                w_strb       <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (!s_axi_awready && !s_axi_wready && !s_axi_bvalid) begin
                s_axi_bvalid <= 1'b1;
                if (aw_addr[7:2] == REG_CONTROL[7:2]) begin
                    control     <= apply_strb(control, w_data, w_strb) & 32'h0000_0001;
                    s_axi_bresp <= RESP_OKAY;
                end else if (aw_addr[7:2] == REG_STATUS[7:2] ||
                             aw_addr[7:2] == REG_WORD[7:2] ||
                             aw_addr[7:2] == REG_COUNT[7:2]) begin
                    s_axi_bresp <= RESP_OKAY;
                end else begin
                    s_axi_bresp <= RESP_SLVERR;
                end
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // AXI4-Lite read channel
    // ----------------------------------------
    always_comb begin
        read_value = 32'h0000_0000;
        read_hit   = 1'b1;
        unique case (s_axi_araddr[7:2])
            REG_CONTROL[7:2]: read_value = control;
            REG_STATUS[7:2]:  read_value = {24'h00_0000, slot, standby_s,
                                            short_s, standby_latch, standby_now};
            REG_WORD[7:2]:    read_value = held_word;
            REG_COUNT[7:2]:   read_value = {16'h0000, word_count};
            default:          read_hit   = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= read_value;
                s_axi_rresp   <= read_hit ? RESP_OKAY : RESP_SLVERR;
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

endmodule
`default_nettype wire

// [verification/hwpd_checker.sv]
// concurrent checks on the head write pulse decoder ports
// assumes binding onto head_write_pulse_decoder, one clock domain
`timescale 1ns/100ps
`default_nettype none
module hwpd_checker
    import hwpd_pkg::*;
(
    input wire logic               sys_clk,
    input wire logic               rst,
    input wire logic               standby_in,
    input wire logic               short_detect,
    input wire logic               s_axi_awvalid,
    input wire logic               s_axi_awready,
    input wire logic               s_axi_wvalid,
    input wire logic               s_axi_wready,
    input wire logic               s_axi_bvalid,
    input wire logic               s_axi_arvalid,
    input wire logic               s_axi_arready,
    input wire logic               s_axi_rvalid,
    input wire logic [NUM_OUT-1:0] hi_switch,
    input wire logic [NUM_OUT-1:0] lo_switch,
    input wire logic               amp_enable,
    input wire logic               vref_enable,
    input wire logic               erase_enable,
    input wire logic               aux_current_enable,
    input wire logic               clamp_enable
);
    // --------
    // sequences
    // --------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    wire logic sw_idle = (hi_switch == '0) && (lo_switch == '0);
    sequence pin_held;
        standby_in [*4];
    endsequence
    sequence short_held;
        short_detect [*4];
    endsequence
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    // --------
    // assertions
    // --------
    chk_pin_standby: assert property (pin_held |-> !amp_enable)
        else $error("standby pin left amplifier on");
    chk_short_standby: assert property (short_held |-> !amp_enable)
        else $error("short left amplifier on");
    chk_standby_off: assert property (!amp_enable |-> sw_idle && !vref_enable && !erase_enable && !clamp_enable)
        else $error("standby with drive still on");
    chk_one_element: assert property ($countones(hi_switch) <= 1 && $countones(lo_switch) <= 1)
        else $error("more than one element driven");
    chk_no_shoot: assert property ((hi_switch & lo_switch) == '0)
        else $error("output with both switches closed");
    chk_clamp_idle: assert property (amp_enable |-> clamp_enable == sw_idle)
        else $error("clamp does not match idle slot");
    chk_erase_aux: assert property (erase_enable |-> aux_current_enable && amp_enable)
        else $error("erase outside aux write");
    chk_aux_outputs: assert property (aux_current_enable |-> (hi_switch[OUT_AUX_A] ^ lo_switch[OUT_AUX_A])
        && (hi_switch[OUT_AUX_B] ^ lo_switch[OUT_AUX_B]))
        else $error("aux current without both aux outputs");
    chk_write_resp: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
        else $error("write response late");
    chk_read_resp: assert property (rd_taken |=> s_axi_rvalid)
        else $error("read response late");
endmodule

bind head_write_pulse_decoder hwpd_checker i_chk (
    .sys_clk, .rst, .standby_in, .short_detect,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
    .hi_switch, .lo_switch, .amp_enable, .vref_enable,
    .erase_enable, .aux_current_enable, .clamp_enable
);
`default_nettype wire

// [verification/serial_ctrl_model.sv]
// recorder controller model: serial write clock and data
// assumes the bench calls send_word; clock stands low between words
`timescale 1ns/100ps
`default_nettype none
module serial_ctrl_model
    import hwpd_pkg::*;
(
    output logic wclk,
    output logic wdata
);
    initial {wclk, wdata} = 2'h0;
    // lsb first, 200 ns bits off clock edges, then an idle gap
    task automatic send_word(input logic [WORD_BITS-1:0] w);
        for (int i = 0; i < WORD_BITS; i++) begin
            #5 wdata = w[i];
            #82.3 wclk = 1'b1;
            #100 wclk = 1'b0;
            #12.7;
        end
        #17 wdata = ~wdata;
        #700;
    endtask
endmodule
`default_nettype wire

// [verification/head_write_pulse_decoder_test.sv]
// self-checking bench for the head write pulse decoder
// assumes the bound checker and the controller model
`timescale 1ns/100ps
`default_nettype none
module head_write_pulse_decoder_test
    import hwpd_pkg::*;
;
    logic               sys_clk, rst, standby_in, short_detect;
    wire logic          wclk, wdata;
    logic [7:0]         s_axi_awaddr, s_axi_araddr;
    logic [31:0]        s_axi_wdata, s_axi_rdata, w, d;
    logic [3:0]         s_axi_wstrb;
    logic [1:0]         s_axi_bresp, s_axi_rresp, r;
    logic               s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic               s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [NUM_OUT-1:0] hi_switch, lo_switch;
    logic               amp_enable, vref_enable, erase_enable, aux_current_enable, clamp_enable;
    int                 n_errors, samples_checked, n_words;

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    head_write_pulse_decoder i_dut (.sys_clk, .rst, .wclk, .wdata, .standby_in, .short_detect,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .hi_switch,
        .lo_switch, .amp_enable, .vref_enable, .erase_enable, .aux_current_enable, .clamp_enable);
    serial_ctrl_model i_ctrl (.wclk, .wdata);

    // --------
    // tasks
    // --------
    task summarize;
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task automatic cycles(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task guard(inout int t);
        if (++t > 100) begin
            n_errors++;
            summarize;
        end
    endtask
    task axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
        int t;
        t = 0;
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            guard(t);
        end while (s_axi_bvalid !== 1'b1);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
        int t;
        t = 0;
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            guard(t);
        end while (s_axi_rvalid !== 1'b1);
        v = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task rd_chk(input string what, input logic [7:0] a, input logic [31:0] e);
        axi_rd(a, d, r);
        check(what, d, e);
        check("rresp", r, RESP_OKAY);
    endtask
    task send(input logic [31:0] v);
        i_ctrl.send_word(v);
        n_words++;
        cycles(10);
    endtask
    function automatic logic [NUM_OUT-1:0] exp_sw(input cmd_t c, input logic hi);
        logic [NUM_OUT-1:0] e;
        e = '0;
        if (!c.aux_playback_select) begin
            e[OUT_AUX_A] = (c.aux_erase_select == hi);
            e[OUT_AUX_B] = (c.aux_erase_select != hi);
        end
        if (!c.data_playback_select) begin
            for (int k = 0; k < NUM_CH; k++) begin
                if (c.channel_direction_bits[k] == hi) e[OUT_CH_BASE+k] = 1'b1;
                else e[OUT_AUX_B] = 1'b1;
            end
        end
        return e;
    endfunction
    task run_case(input logic [31:0] v);
        cmd_t               c;
        logic               sb, sa, se, sc;
        logic [NUM_OUT-1:0] sh, sl;
        c = cmd_t'(v[CMD_BITS-1:0]);
        sb = c.data_playback_select & c.aux_playback_select;
        send(v);
        {sh, sl, sa, se, sc} = '0;
        fork
            send(v);
            repeat (256) begin
                @(negedge sys_clk);
                sh |= hi_switch;
                sl |= lo_switch;
                sa |= aux_current_enable;
                se |= erase_enable;
                sc |= clamp_enable;
            end
        join
        check("amp", amp_enable, !sb);
        check("vref", vref_enable, !sb);
        check("hi_sw", sh, exp_sw(c, 1'b1));
        check("lo_sw", sl, exp_sw(c, 1'b0));
        check("aux", sa, !sb & !c.aux_playback_select);
        check("erase", se, !sb & !c.aux_playback_select & c.aux_erase_select);
        check("clamp", sc, !sb);
        rd_chk("word", REG_WORD, v);
    endtask

    // --------
    // main sequence
    // --------
    initial begin
        {n_errors, samples_checked, n_words} = '0;
        {rst, standby_in, short_detect} = 3'h4;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hF;
        void'($urandom(96));
        cycles(12);
        rst <= 1'b0;
        cycles(1);
        check("amp_rst", amp_enable, 1'b0);
        rd_chk("ctl_rst", REG_CONTROL, CONTROL_RST);
        rd_chk("word_rst", REG_WORD, WORD_RST);
        axi_rd(8'h40, d, r);
        check("bad_rd", r, RESP_SLVERR);
        axi_wr(8'h44, 32'h0000_0000, r);
        check("bad_wr", r, RESP_SLVERR);
        for (int m = 0; m < 10; m++) begin
            w = $urandom();
            w[2:0] = (m < 8) ? m[2:0] : 3'h0;
            if (m >= 8) w[10:3] = (m == 8) ? 8'hFF : 8'h00;
            run_case(w);
        end
        standby_in <= 1'b1;
        cycles(8);
        check("pin", amp_enable, 1'b0);
        send(w);
        check("pin_word", amp_enable, 1'b0);
        standby_in <= 1'b0;
        cycles(8);
        check("latch", amp_enable, 1'b0);
        send(w);
        check("unlatch", amp_enable, 1'b1);
        short_detect <= 1'b1;
        cycles(8);
        check("short", amp_enable, 1'b0);
        rd_chk("short_word", REG_WORD, w);
        short_detect <= 1'b0;
        cycles(8);
        check("resume", amp_enable, 1'b1);
        axi_wr(REG_CONTROL, 32'h0000_0001, r);
        rd_chk("ctl", REG_CONTROL, 32'h0000_0001);
        check("ctl_sb", amp_enable, 1'b0);
        axi_wr(REG_CONTROL, 32'h0000_0000, r);
        axi_wr(REG_WORD, 32'h0000_0000, r);
        rd_chk("word_ro", REG_WORD, w);
        rd_chk("count", REG_COUNT, n_words);
        summarize;
    end
    initial begin
        cycles(90000);
        n_errors++;
        summarize;
    end
endmodule
`default_nettype wire
